/* File: logic/lam_cell_map.sv */
// Purpose: Maps one text attribute or graphics pixel to a panel level
// Assumes: Pure combinational, used by the fetch pipeline
// Notes: Colour 0 black, 7 white, low three bits of each nibble
`timescale 1ns/1ps
module lam_cell_map
(
	// Cell input
	input wire logic gfx,
	input wire logic [7:0] attr,
	input wire logic [1:0] pixel,
	input wire logic glyph_bit,
	input wire logic last_line,
	input wire lam_pkg::lam_int_type int_map,
	// Result
	output lam_pkg::lam_lvl_type level,
	output logic use_alt
);
	import lam_pkg::*;
	wire logic [2:0] fg = attr[2:0];
	wire logic [2:0] bg = attr[6:4];
	wire logic intense = attr[3];
	wire logic fg_white = (fg == 3'h7);
	wire logic bg_black = (bg == 3'h0);
	wire logic hidden = (fg == 3'h0) && bg_black;
	wire logic solid = (fg == bg) && !hidden;
	wire logic normal = fg_white && bg_black;
	// Reverse covers black-on-white and every other mixed pair
	wire logic reverse = !normal && !hidden && !solid;
	wire logic int_rev = intense && (int_map == LAM_INT_REVERSE);
	wire logic int_ul = intense && (int_map == LAM_INT_UNDERLINE);
	wire logic ink = solid ? 1'b1 : (glyph_bit | (int_ul & last_line));
	wire logic txt_on = hidden ? 1'b0 : (ink ^ reverse ^ int_rev);
	assign use_alt = intense && (int_map == LAM_INT_ALTFONT);
	// Only two text states reach the panel, gray or black
	assign level = gfx ? lam_lvl_type'(pixel) :
		(txt_on ? LAM_LVL_BLACK : LAM_LVL_GRAY);
endmodule

/* File: logic/lam_defs.svh */
// Purpose: Offsets, field positions, reset values and raster geometry
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by every design file that needs the numbers
`ifndef LAM_DEFS_SVH
`define LAM_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define LAM_OFF_CTRL 12'h000
`define LAM_OFF_STAT 12'h004
`define LAM_OFF_BUF 12'h008
`define LAM_OFF_BUFDATA 12'h00C
`define LAM_OFF_FONT 12'h010
`define LAM_OFF_FONTDATA 12'h014
// ****************************************
// Control fields
// ****************************************
`define LAM_CTRL_GFX 0
`define LAM_CTRL_VIDEO 1
`define LAM_CTRL_RANGE 2
`define LAM_CTRL_RANGE_OVR 3
`define LAM_CTRL_INT_LO 4
`define LAM_CTRL_INT_HI 5
`define LAM_CTRL_RST 32'h0000_0002
// ****************************************
// Raster and cell geometry
// ****************************************
`define LAM_COLS 640
`define LAM_ROWS 200
`define LAM_CELL 8
`endif

/* File: logic/lam_mapper.sv */
// Purpose: LCD attribute mapper with refresh buffer, fonts and APB
// Assumes: Single clock pclk at 250 MHz, inputs synchronous to it
// Notes: Host buffer and font writes run beside refresh reads, no arbitration
`timescale 1ns/1ps
`include "lam_defs.svh"
module lam_mapper
#(
	parameter int COLS = `LAM_COLS,
	parameter int ROWS = `LAM_ROWS,
	parameter int BUF_WORDS = 4096
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// System
	input wire logic crt_present,
	input wire logic [7:0] rom_font_data,
	output logic [10:0] rom_font_addr,
	output logic font_loading,
	output logic mono_range,
	// Panel
	output lam_pkg::lam_pel_type pel
);
	import lam_pkg::*;
	// ****************************************
	// Storage
	// ****************************************
	logic [15:0] vram [BUF_WORDS];
	logic [7:0] font_main [2048];
	logic [7:0] font_alt [2048];
	// ****************************************
	// Registers
	// ****************************************
	logic [5:0] ctrl_q;
	logic [11:0] buf_addr_q;
	logic [11:0] font_addr_q;
	logic range_valid_q;
	logic mono_q;
	logic [11:0] load_q;
	logic [9:0] x_q;
	logic [7:0] y_q;
	lam_st_type st_q;
	logic [15:0] cell_q;
	logic [7:0] glyph_q;
	logic [31:0] prdata_q;
	lam_pel_type pel_q;
	// ****************************************
	// APB decode
	// ****************************************
	wire logic acc = psel && penable && clk_en;
	wire logic wr = acc && pwrite;
	wire logic rd = acc && !pwrite;
	// Read data is caught in setup so it stands at the access edge
	wire logic rd_setup = psel && !penable && !pwrite && clk_en;
	wire logic hit_ctrl = (paddr == `LAM_OFF_CTRL);
	wire logic hit_stat = (paddr == `LAM_OFF_STAT);
	wire logic hit_buf = (paddr == `LAM_OFF_BUF);
	wire logic hit_bd = (paddr == `LAM_OFF_BUFDATA);
	wire logic hit_font = (paddr == `LAM_OFF_FONT);
	wire logic hit_fd = (paddr == `LAM_OFF_FONTDATA);
	wire logic mapped = hit_ctrl || hit_stat || hit_buf || hit_bd ||
		hit_font || hit_fd;
	wire logic loading = !load_q[11] || !range_valid_q;
	// Host writes are one cycle; refresh simply reads again next slot
	wire logic host_buf_wr = wr && hit_bd && !loading;
	wire logic host_font_wr = wr && hit_fd && !loading;
	wire logic gfx = ctrl_q[`LAM_CTRL_GFX];
	wire logic video_on = ctrl_q[`LAM_CTRL_VIDEO];
	wire lam_int_type int_map =
		lam_int_type'(ctrl_q[`LAM_CTRL_INT_HI:`LAM_CTRL_INT_LO]);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_q;
	assign mono_range = mono_q;
	assign font_loading = loading;
	assign rom_font_addr = load_q[10:0];
	assign pel = pel_q;
	// ****************************************
	// Read data
	// ****************************************
	logic [31:0] rd_d;
	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (hit_ctrl)
			rd_d = {26'h0, ctrl_q};
		else if (hit_stat)
			rd_d = {12'h0, loading, mono_q, y_q, x_q};
		else if (hit_buf)
			rd_d = {20'h0, buf_addr_q};
		else if (hit_bd)
			rd_d = {16'h0, vram[buf_addr_q]};
		else if (hit_font)
			rd_d = {20'h0, font_addr_q};
		else if (hit_fd)
			rd_d = {24'h0, font_addr_q[11] ? font_alt[font_addr_q[10:0]] :
				font_main[font_addr_q[10:0]]};
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (rd_setup)
			prdata_q <= rd_d;
	end
	// ****************************************
	// Control and address range
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= 6'(`LAM_CTRL_RST);
			buf_addr_q <= 12'h000;
			font_addr_q <= 12'h000;
			range_valid_q <= 1'b0;
			mono_q <= 1'b0;
		end
		else if (clk_en)
		begin
			// Strap caught after release, never under reset
			if (!range_valid_q)
			begin
				range_valid_q <= 1'b1;
				mono_q <= crt_present;
			end
			if (wr && hit_ctrl)
			begin
				ctrl_q <= pwdata[5:0];
				if (pwdata[`LAM_CTRL_RANGE_OVR])
					mono_q <= pwdata[`LAM_CTRL_RANGE];
			end
			if (wr && hit_buf)
				buf_addr_q <= pwdata[11:0];
			else if (host_buf_wr || (rd && hit_bd))
				buf_addr_q <= buf_addr_q + 12'h001;
			if (wr && hit_font)
				font_addr_q <= pwdata[11:0];
			else if (host_font_wr || (rd && hit_fd))
				font_addr_q <= font_addr_q + 12'h001;
		end
	end
	// ****************************************
	// Font load at power-on
	// ****************************************
	// Both fonts get the same ROM set; host may rewrite either later
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			load_q <= 12'h000;
		else if (clk_en && !load_q[11])
			load_q <= load_q + 12'h001;
	end
	always_ff @(posedge pclk)
	begin
		if (clk_en && !load_q[11])
		begin
			font_main[load_q[10:0]] <= rom_font_data;
			font_alt[load_q[10:0]] <= rom_font_data;
		end
		else if (host_font_wr && !font_addr_q[11])
			font_main[font_addr_q[10:0]] <= pwdata[7:0];
		else if (host_font_wr)
			font_alt[font_addr_q[10:0]] <= pwdata[7:0];
		if (host_buf_wr)
			vram[buf_addr_q] <= pwdata[15:0];
	end
	// ****************************************
	// Refresh fetch
	// ****************************************
	// Each pel takes three cycles: char, attr/glyph, font and output
	wire logic [6:0] col = x_q[9:3];
	wire logic [4:0] row = y_q[7:3];
	wire logic [11:0] txt_idx = 12'(row * 80 + col);
	wire logic [11:0] gfx_idx = 12'({y_q[0], 13'(y_q[7:1] * 80)} >> 1)
		+ 12'(x_q[9:4]);
	wire logic [1:0] gfx_pix = 2'(cell_q >> {~x_q[3:1], 1'b0});
	wire logic last_col = (x_q == 10'(COLS - 1));
	wire logic last_row = (y_q == 8'(ROWS - 1));
	lam_lvl_type map_level;
	logic map_alt;
	lam_cell_map u_map
	(
		.gfx(gfx),
		.attr(cell_q[15:8]),
		.pixel(gfx_pix),
		.glyph_bit(glyph_q[~x_q[2:0]]),
		.last_line(y_q[2:0] == 3'h7),
		.int_map(int_map),
		.level(map_level),
		.use_alt(map_alt)
	);
	wire logic [10:0] glyph_addr = {cell_q[7:0], y_q[2:0]};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= LAM_ST_IDLE;
			x_q <= 10'h000;
			y_q <= 8'h00;
			cell_q <= 16'h0000;
			glyph_q <= 8'h00;
			pel_q <= '0;
		end
		else if (clk_en)
		begin
			pel_q.valid <= 1'b0;
			case (st_q)
				LAM_ST_IDLE:
					if (!loading)
						st_q <= LAM_ST_CHAR;
				LAM_ST_CHAR:
				begin
					cell_q <= vram[gfx ? gfx_idx : txt_idx];
					st_q <= LAM_ST_ATTR;
				end
				LAM_ST_ATTR:
				begin
					glyph_q <= map_alt ? font_alt[glyph_addr] :
						font_main[glyph_addr];
					st_q <= LAM_ST_FONT;
				end
				LAM_ST_FONT:
				begin
					pel_q.valid <= 1'b1;
					pel_q.x <= x_q;
					pel_q.y <= y_q;
					// Video off shows gray; host updates never stall the refresh
					pel_q.level <= video_on ? map_level : LAM_LVL_GRAY;
					x_q <= last_col ? 10'h000 : x_q + 10'h001;
					if (last_col)
						y_q <= last_row ? 8'h00 : y_q + 8'h01;
					st_q <= LAM_ST_CHAR;
				end
				default:
					st_q <= LAM_ST_IDLE;
			endcase
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	property p_x_range;
		@(posedge pclk) disable iff (!presetn)
		pel_q.valid |-> (pel_q.x < 10'(COLS)) && (pel_q.y < 8'(ROWS));
	endproperty
	a_x_range: assert property (p_x_range)
		else $error("pel outside raster");
	property p_wrap;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && st_q == LAM_ST_FONT && last_col) |=> (x_q == 10'h000);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("line did not wrap");
	property p_strap;
		@(posedge pclk) disable iff (!presetn)
		(presetn && clk_en && !range_valid_q) |=>
		(mono_q == $past(crt_present));
	endproperty
	a_strap: assert property (p_strap)
		else $error("default range wrong");
	property p_override;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_ctrl && range_valid_q && pwdata[`LAM_CTRL_RANGE_OVR])
		|=> (mono_q == $past(pwdata[`LAM_CTRL_RANGE]));
	endproperty
	a_override: assert property (p_override)
		else $error("range select ignored");
	property p_load;
		@(posedge pclk) disable iff (!presetn)
		(presetn && clk_en && !load_q[11]) |=>
		(load_q == $past(load_q) + 12'h001);
	endproperty
	a_load: assert property (p_load)
		else $error("font load stalled");
	property p_buf_step;
		@(posedge pclk) disable iff (!presetn)
		host_buf_wr |=> (buf_addr_q == $past(buf_addr_q) + 12'h001);
	endproperty
	a_buf_step: assert property (p_buf_step)
		else $error("host write lost");
	property p_ready;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable) |-> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("host access stalled");
	property p_two_state;
		@(posedge pclk) disable iff (!presetn)
		(pel_q.valid && !$past(gfx)) |->
		(pel_q.level inside {LAM_LVL_GRAY, LAM_LVL_BLACK});
	endproperty
	a_two_state: assert property (p_two_state)
		else $error("text pel not two-state");
endmodule

/* File: logic/lam_pkg.sv */
// Purpose: Types shared by the attribute mapper files
// Assumes: Constants come from lam_defs.svh
// Notes: Levels are panel grey shades, 0 lightest
package lam_pkg;
	typedef enum logic [1:0]
	{
		LAM_INT_REVERSE = 2'b00,
		LAM_INT_UNDERLINE = 2'b01,
		LAM_INT_ALTFONT = 2'b10,
		LAM_INT_NONE = 2'b11
	} lam_int_type;
	typedef enum logic [1:0]
	{
		LAM_LVL_GRAY = 2'b00,
		LAM_LVL_DARK1 = 2'b01,
		LAM_LVL_DARK2 = 2'b10,
		LAM_LVL_BLACK = 2'b11
	} lam_lvl_type;
	typedef enum logic [1:0]
	{
		LAM_ST_IDLE = 2'b00,
		LAM_ST_CHAR = 2'b01,
		LAM_ST_ATTR = 2'b10,
		LAM_ST_FONT = 2'b11
	} lam_st_type;
	typedef struct packed
	{
		logic valid;
		logic [9:0] x;
		logic [7:0] y;
		lam_lvl_type level;
	} lam_pel_type;
endpackage

/* File: verification/lam_rom_model.sv */
// Purpose: Font ROM that the mapper copies into its RAM fonts
// Assumes: Combinational read, data in the cycle of the address
// Notes: Codes 80h and up give solid glyphs, lower codes blank ones
`timescale 1ns/1ps
module lam_rom_model
(
	// Font port
	input wire logic [10:0] rom_font_addr,
	output logic [7:0] rom_font_data
);
	// ****************************************
	// Glyph source
	// ****************************************
	// Two glyph kinds are enough to tell foreground from background
	assign rom_font_data = rom_font_addr[10] ? 8'hFF : 8'h00;
endmodule

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the attribute mapper
// Assumes: Small raster so that a frame takes a few hundred cycles
// Notes: Each level check waits for the second pass over a pel
`timescale 1ns/1ps
`include "lam_defs.svh"
module tb_top;
	import lam_pkg::*;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic pclk, presetn, psel, penable, pwrite, crt_present, pready;
	logic pslverr, font_loading, mono_range, err, clk_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] rom_font_addr;
	logic [7:0] rom_font_data;
	logic [1:0] lv;
	lam_pel_type pel;
	int fails, n_checks;
	lam_mapper #(.COLS(16), .ROWS(8)) dut_u
	(
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .crt_present(crt_present),
		.rom_font_data(rom_font_data), .rom_font_addr(rom_font_addr),
		.font_loading(font_loading), .mono_range(mono_range), .pel(pel)
	);
	lam_rom_model rom_u
	(
		.rom_font_addr(rom_font_addr), .rom_font_data(rom_font_data)
	);
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tmo();
		fails++;
		end_of_test();
	endtask
	// One APB transfer; read data and error are taken at the access edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (i >= 50)
			tmo();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Let the access edge settle before callers look at outputs
		@(posedge pclk);
	endtask
	task automatic rst(input logic crt);
		int i;
		crt_present <= crt;
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		check(32'(font_loading), 32'h1);
		presetn <= 1'b1;
		for (i = 0; i < 3000 && font_loading !== 1'b0; i++)
			@(posedge pclk);
		if (i >= 3000)
			tmo();
	endtask
	// Skips the first pass, which may show data from before a write
	task automatic pel_at(input int x, input int y);
		int i, n;
		n = 0;
		for (i = 0; i < 4000; i++)
		begin
			@(negedge pclk);
			if (pel.valid === 1'b1 && pel.x == x && pel.y == y)
				n++;
			if (n == 2)
			begin
				lv = pel.level;
				return;
			end
		end
		tmo();
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_range();
		rst(1'b0);
		check(32'(mono_range), 32'h0);
		apb(1'b0, `LAM_OFF_CTRL, 32'h0);
		check(rd, `LAM_CTRL_RST);
		rst(1'b1);
		check(32'(mono_range), 32'h1);
		apb(1'b0, `LAM_OFF_STAT, 32'h0);
		check(32'(rd[19:18]), 32'h1);
		apb(1'b1, `LAM_OFF_CTRL, 32'h0000_000A);
		check(32'(mono_range), 32'h0);
		apb(1'b1, `LAM_OFF_CTRL, 32'h0000_000E);
		check(32'(mono_range), 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		check(32'(err), 32'h1);
		$display("range test done");
	endtask
	task automatic t_text();
		logic [7:0] at [5] = '{8'h07, 8'h70, 8'h12, 8'h11, 8'h00};
		logic [1:0] e0 [5] = '{2'h0, 2'h3, 2'h3, 2'h3, 2'h0};
		logic [1:0] e1 [5] = '{2'h3, 2'h0, 2'h0, 2'h3, 2'h0};
		// Video stays on while the buffer is rewritten
		apb(1'b1, `LAM_OFF_CTRL, 32'h0000_0002);
		for (int k = 0; k < 5; k++)
		begin
			apb(1'b1, `LAM_OFF_BUF, 32'h0);
			apb(1'b1, `LAM_OFF_BUFDATA, {16'h0, at[k], 8'h00});
			apb(1'b1, `LAM_OFF_BUFDATA, {16'h0, at[k], 8'hFF});
			pel_at(7, 0);
			check(32'(lv), 32'(e0[k]));
			pel_at(8, 0);
			check(32'(lv), 32'(e1[k]));
		end
		apb(1'b1, `LAM_OFF_BUF, 32'h1);
		apb(1'b0, `LAM_OFF_BUFDATA, 32'h0);
		check(32'(rd[15:0]), 32'h0000_00FF);
		$display("text test done");
	endtask
	task automatic t_int();
		logic [1:0] e0 [4] = '{2'h3, 2'h0, 2'h3, 2'h0};
		logic [1:0] e7 [4] = '{2'h3, 2'h3, 2'h0, 2'h0};
		apb(1'b1, `LAM_OFF_FONT, 32'h0000_0800);
		apb(1'b1, `LAM_OFF_FONTDATA, 32'h0000_00FF);
		apb(1'b1, `LAM_OFF_BUF, 32'h0);
		apb(1'b1, `LAM_OFF_BUFDATA, 32'h0000_0F00);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, `LAM_OFF_CTRL, 32'h2 | (m << 4));
			pel_at(0, 0);
			check(32'(lv), 32'(e0[m]));
			pel_at(0, 7);
			check(32'(lv), 32'(e7[m]));
		end
		$display("intensify test done");
	endtask
	task automatic t_gfx();
		apb(1'b1, `LAM_OFF_CTRL, 32'h0000_0003);
		for (int p = 0; p < 4; p++)
		begin
			apb(1'b1, `LAM_OFF_BUF, 32'h0);
			apb(1'b1, `LAM_OFF_BUFDATA, 32'(p * 16'h5555));
			pel_at(0, 0);
			check(32'(lv), 32'(p));
		end
		$display("graphics test done");
	endtask
	// Clock enable low must freeze the raster walk
	task automatic t_hold();
		lam_pel_type held;
		@(posedge pclk);
		clk_en <= 1'b0;
		@(negedge pclk);
		held = pel;
		repeat (20) @(negedge pclk);
		check(32'(pel), 32'(held));
		@(posedge pclk);
		clk_en <= 1'b1;
		$display("hold test done");
	endtask
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		crt_present = 1'b0;
		clk_en = 1'b1;
		fails = 0;
		n_checks = 0;
		t_range();
		t_text();
		t_int();
		t_gfx();
		t_hold();
		end_of_test();
	end
endmodule
